// ---- logic/voice_chan_format.sv ----
`timescale 1ns/1ps
module voice_chan_format
  import voice_dm_pkg::*;
(
  input  wire voice_dm_pkg::fmt_t fmt,
  input  wire logic               lin8_tx,
  input  wire logic               lin8_rx,
  input  wire logic [7:0]         mask,
  input  wire logic [15:0]        tx_lin,
  output wire logic [15:0]        tx_word,
  input  wire logic [15:0]        rx_word,
  output wire logic [15:0]        rx_lin
);

  // ================================================================
  // Companding
  // ================================================================
  function automatic logic [7:0] seg_code(input logic [12:0] m, input logic [4:0] lo);
    logic [2:0]  e;
    logic [12:0] sh;
    e = 3'h0;
    for (int i = 1; i < 8; i++)
    begin
      if (m >= (13'(lo) << i)) e = 3'(i);
    end
    sh = (e == 3'h0) ? (m >> 1) : (m >> e);
    seg_code = {1'b0, e, sh[3:0]};
  endfunction

  function automatic logic [7:0] alaw_enc(input logic [15:0] s);
    logic [15:0] mag;
    mag = s[15] ? ~s : s;
    alaw_enc = ({~s[15], 7'h00} | seg_code({1'b0, mag[14:3]}, 5'h10)) ^ 8'h55;
  endfunction

  function automatic logic [7:0] mulaw_enc(input logic [15:0] s);
    logic [15:0] mag;
    logic [13:0] b;
    logic [12:0] m;
    logic [7:0]  c;
    logic [2:0]  e;
    mag = s[15] ? ~s : s;
    b = {1'b0, mag[14:2]} + 14'd33;
    m = b[13] ? 13'h1fff : b[12:0];
    e = 3'h0;
    for (int i = 1; i < 8; i++)
    begin
      if (m >= (13'h0020 << i)) e = 3'(i);
    end
    c = {1'b0, e, 4'(m >> ({1'b0, e} + 4'h1))};
    mulaw_enc = ~{s[15], c[6:0]};
  endfunction

  function automatic logic [15:0] alaw_dec(input logic [7:0] c);
    logic [7:0]  x;
    logic [15:0] v;
    x = c ^ 8'h55;
    v = (x[6:4] == 3'h0) ? {11'h0, x[3:0], 1'b1} : ({11'h1, x[3:0], 1'b1} << (x[6:4] - 3'h1));
    v = v << 3;
    alaw_dec = x[7] ? v : 16'(-v);
  endfunction

  function automatic logic [15:0] mulaw_dec(input logic [7:0] c);
    logic [7:0]  x;
    logic [15:0] v;
    x = ~c;
    v = (({9'h0, x[3:0], 3'h0} + 16'd132) << x[6:4]) - 16'd132;
    v = v << 2;
    mulaw_dec = x[7] ? 16'(-v) : v;
  endfunction

  // ================================================================
  // Transmit and receive conversion, mask on 8-bit formats
  // ================================================================
  wire logic [7:0] tx_byte = (fmt == FMT_ALAW)  ? alaw_enc(tx_lin) :
                             (fmt == FMT_MULAW) ? mulaw_enc(tx_lin) :
                             {tx_lin[15] ^ lin8_tx, tx_lin[14:8]};
  wire logic [7:0] rx_byte = rx_word[7:0] ^ mask;

  assign tx_word = (fmt == FMT_LIN16) ? tx_lin : {8'h00, tx_byte ^ mask};
  assign rx_lin  = (fmt == FMT_LIN16) ? rx_word :
                   (fmt == FMT_ALAW)  ? alaw_dec(rx_byte) :
                   (fmt == FMT_MULAW) ? mulaw_dec(rx_byte) :
                   {rx_byte[7] ^ lin8_rx, rx_byte[6:0], 8'h00};

endmodule

// ---- logic/voice_data_manip.sv ----
`timescale 1ns/1ps
module voice_data_manip
  import voice_dm_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        frame_sync,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  input  wire logic [15:0] codec_tx_sample,
  output logic      [15:0] codec_rx_sample,
  input  wire logic [15:0] bus_in_chan1,
  input  wire logic [15:0] bus_in_chan2,
  output logic      [15:0] bus_out_chan1,
  output logic      [15:0] bus_out_chan2,
  output logic             bus_out_chan1_oe_n,
  output logic             bus_out_chan2_oe_n,
  input  wire logic        atten_tx_mode,
  input  wire logic [7:0]  rx_switch_atten_req,
  output logic      [7:0]  rx_switch_atten,
  output logic      [7:0]  loudspeaker_amp,
  output logic             speakerphone_enable,
  input  wire logic [15:0] sidetone_pre,
  input  wire logic [15:0] sidetone_post,
  output logic      [15:0] sidetone_sample,
  output logic             loop_digital_shaper,
  output logic             loop_analog_front,
  output logic             loop_analog_converter,
  output logic             loop_analog_shaper
);

  import voice_dm_pkg::*;

  // ================================================================
  // Arithmetic helpers
  // ================================================================
  function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {a[15], a} + {b[15], b};
    if (s[16] != s[15])
      sat_add = s[16] ? 16'h8000 : 16'h7fff;
    else
      sat_add = s[15:0];
  endfunction

  function automatic logic [15:0] conf_atten(input logic [15:0] x, input logic [7:0] att);
    conf_atten = 16'($signed(x) >>> att[2:0]);  // 6 dB per step
  endfunction

  // ================================================================
  // Written registers
  // ================================================================
  logic [7:0]  source_select_ff;
  logic [7:0]  format_select_ff;
  logic [7:0]  channel_one_mask_ff;
  logic [7:0]  channel_two_mask_ff;
  logic [7:0]  general_ctrl_ff;
  logic [7:0]  path_ctrl_ff;
  logic [7:0]  atten_ctrl_ff;
  logic [7:0]  loudspeaker_level_ff;
  logic [7:0]  loop_ctrl_ff;
  logic [7:0]  cram [0:127];
  voice_cfg_t  active_cfg_ff;

  wire logic wr_src   = reg_wr && (reg_addr == ADDR_SOURCE_SEL);
  wire logic wr_fmt   = reg_wr && (reg_addr == ADDR_FORMAT_SEL);
  wire logic wr_ch1_mask_value = reg_wr && (reg_addr == ADDR_CH1_MASK);
  wire logic wr_ch2_mask_value = reg_wr && (reg_addr == ADDR_CH2_MASK);
  wire logic wr_gen   = reg_wr && (reg_addr == ADDR_GENERAL_CTRL);
  wire logic wr_path  = reg_wr && (reg_addr == ADDR_PATH_CTRL);
  wire logic wr_att   = reg_wr && (reg_addr == ADDR_ATTEN_CTRL);
  wire logic wr_lspk  = reg_wr && (reg_addr == ADDR_LSPK_CTRL);
  wire logic wr_loop  = reg_wr && (reg_addr == ADDR_LOOP_CTRL);
  wire logic wr_cram  = reg_wr && reg_addr[7];

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      source_select_ff     <= RST_SOURCE_SEL;
      format_select_ff     <= RST_FORMAT_SEL;
      channel_one_mask_ff  <= RST_MASK;
      channel_two_mask_ff  <= RST_MASK;
      general_ctrl_ff      <= RST_CTRL;
      path_ctrl_ff         <= RST_CTRL;
      atten_ctrl_ff        <= RST_CTRL;
      loudspeaker_level_ff <= RST_CTRL;
      loop_ctrl_ff         <= RST_CTRL;
    end
    else
    begin
      if (wr_src)   source_select_ff     <= reg_wdata;
      if (wr_fmt)   format_select_ff     <= reg_wdata;
      if (wr_ch1_mask_value) channel_one_mask_ff  <= reg_wdata;
      if (wr_ch2_mask_value) channel_two_mask_ff  <= reg_wdata;
      if (wr_gen)   general_ctrl_ff      <= reg_wdata;
      if (wr_path)  path_ctrl_ff         <= reg_wdata;
      if (wr_att)   atten_ctrl_ff        <= reg_wdata;
      if (wr_lspk)  loudspeaker_level_ff <= reg_wdata;
      if (wr_loop)  loop_ctrl_ff         <= reg_wdata;
    end
  end

  // Coefficient memory has no reset; software loads it after power-up
  always_ff @(posedge ref_clk)
  begin
    if (wr_cram) cram[reg_addr[6:0]] <= reg_wdata;
  end

  // ================================================================
  // Frame-aligned configuration
  // ================================================================
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      active_cfg_ff <= {RST_MASK, RST_MASK, RST_FORMAT_SEL, RST_SOURCE_SEL};
    else if (frame_sync)
      active_cfg_ff <= {channel_one_mask_ff, channel_two_mask_ff,
                        format_select_ff, source_select_ff};
  end

  // ================================================================
  // Read-back of every register and coefficient cell
  // ================================================================
  wire logic [7:0] rd_mux =
    reg_addr[7]                        ? cram[reg_addr[6:0]]  :
    (reg_addr == ADDR_SOURCE_SEL)      ? source_select_ff     :
    (reg_addr == ADDR_FORMAT_SEL)      ? format_select_ff     :
    (reg_addr == ADDR_CH1_MASK)        ? channel_one_mask_ff  :
    (reg_addr == ADDR_CH2_MASK)        ? channel_two_mask_ff  :
    (reg_addr == ADDR_GENERAL_CTRL)    ? general_ctrl_ff      :
    (reg_addr == ADDR_PATH_CTRL)       ? path_ctrl_ff         :
    (reg_addr == ADDR_ATTEN_CTRL)      ? atten_ctrl_ff        :
    (reg_addr == ADDR_LSPK_CTRL)       ? loudspeaker_level_ff :
    (reg_addr == ADDR_LOOP_CTRL)       ? loop_ctrl_ff         : 8'h00;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rdata  <= reg_rd ? rd_mux : 8'h00;
      reg_rvalid <= reg_rd;
    end
  end

  // ================================================================
  // Control bits
  // ================================================================
  wire logic monitor_enable    = general_ctrl_ff[1] && general_ctrl_ff[0];
  wire logic sidetone_gain     = path_ctrl_ff[0];
  wire logic sidetone_tap_sel  = path_ctrl_ff[1];
  wire logic monitor_level_sel = atten_ctrl_ff[0];
  wire logic loop_sample_reg   = loop_ctrl_ff[0];
  wire logic loop_processor    = loop_ctrl_ff[1];
  wire logic loop_sidetone     = loop_ctrl_ff[6];

  // ================================================================
  // Format conversion per channel
  // ================================================================
  wire logic [15:0] ch1_rx_lin;
  wire logic [15:0] ch2_rx_lin;
  wire logic [15:0] ch1_tx_word;
  wire logic [15:0] ch2_tx_word;
  logic      [15:0] ch1_tx_lin;
  logic      [15:0] ch2_tx_lin;

  voice_chan_format u_ch1_fmt (
    .fmt     (active_cfg_ff.fmt.ch1_format_sel),
    .lin8_tx (active_cfg_ff.fmt.ch1_linear8_tx),
    .lin8_rx (active_cfg_ff.fmt.ch1_linear8_rx),
    .mask    (active_cfg_ff.ch1_mask_value),
    .tx_lin  (ch1_tx_lin),
    .tx_word (ch1_tx_word),
    .rx_word (bus_in_chan1),
    .rx_lin  (ch1_rx_lin)
  );

  voice_chan_format u_ch2_fmt (
    .fmt     (active_cfg_ff.fmt.ch2_format_sel),
    .lin8_tx (active_cfg_ff.fmt.ch2_linear8_tx),
    .lin8_rx (active_cfg_ff.fmt.ch2_linear8_rx),
    .mask    (active_cfg_ff.ch2_mask_value),
    .tx_lin  (ch2_tx_lin),
    .tx_word (ch2_tx_word),
    .rx_word (bus_in_chan2),
    .rx_lin  (ch2_rx_lin)
  );

  // ================================================================
  // Source selection and summing
  // ================================================================
  wire logic [15:0] ch1_att = conf_atten(ch1_rx_lin, cram[CRAM_IDX_ATT1]);
  wire logic [15:0] ch2_att = conf_atten(ch2_rx_lin, cram[CRAM_IDX_ATT2]);

  // Sidetone tap and gain stage
  wire logic [15:0] st_tap = sidetone_tap_sel ? sidetone_post : sidetone_pre;
  wire logic [15:0] st_out = sidetone_gain ? st_tap : 16'h0000;

  // Transmit voice: same with or without monitoring; sidetone loop adds in
  wire logic [15:0] tx_voice =
    loop_processor ? codec_rx_sample :
    loop_sidetone  ? sat_add(codec_tx_sample, st_out) :
    codec_tx_sample;

  always_comb
  begin
    case (active_cfg_ff.src.tx_ch1_source_sel)
      TXSRC_CODEC: ch1_tx_lin = tx_voice;
      TXSRC_SUM:   ch1_tx_lin = sat_add(tx_voice, ch2_att);
      TXSRC_BUS:   ch1_tx_lin = ch2_att;
      default:     ch1_tx_lin = 16'h0000;
    endcase
    case (active_cfg_ff.src.tx_ch2_source_sel)
      TXSRC_CODEC: ch2_tx_lin = tx_voice;
      TXSRC_SUM:   ch2_tx_lin = sat_add(tx_voice, ch1_att);
      TXSRC_BUS:   ch2_tx_lin = ch1_att;
      default:     ch2_tx_lin = 16'h0000;
    endcase
  end

  logic [15:0] nxt_rx;
  always_comb
  begin
    case (active_cfg_ff.src.rx_source_sel)
      RXSRC_CH1: nxt_rx = ch1_att;
      RXSRC_CH2: nxt_rx = ch2_att;
      RXSRC_SUM: nxt_rx = sat_add(ch1_att, ch2_att);
      default:   nxt_rx = 16'h0000;
    endcase
  end

  // Digital loop via sample register returns the bus input unchanged
  wire logic [15:0] nxt_out1 = loop_sample_reg ? bus_in_chan1 : ch1_tx_word;
  wire logic [15:0] nxt_out2 = loop_sample_reg ? bus_in_chan2 : ch2_tx_word;

  // ================================================================
  // Frame output registers
  // ================================================================
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      bus_out_chan1      <= 16'h0000;
      bus_out_chan2      <= 16'h0000;
      bus_out_chan1_oe_n <= 1'b1;
      bus_out_chan2_oe_n <= 1'b1;
      codec_rx_sample    <= 16'h0000;
    end
    else if (frame_sync)
    begin
      bus_out_chan1      <= active_cfg_ff.src.tx_ch1_enable ? nxt_out1 : 16'h0000;
      bus_out_chan2      <= active_cfg_ff.src.tx_ch2_enable ? nxt_out2 : 16'h0000;
      bus_out_chan1_oe_n <= !active_cfg_ff.src.tx_ch1_enable;
      bus_out_chan2_oe_n <= !active_cfg_ff.src.tx_ch2_enable;
      codec_rx_sample    <= nxt_rx;
    end
  end

  // ================================================================
  // Controlled monitoring
  // ================================================================
  wire logic       lspk_above = loudspeaker_level_ff < LSPK_ATT_9P5DB;
  wire logic [7:0] mon_level  = monitor_level_sel ? LSPK_ATT_21P5DB : LSPK_ATT_9P5DB;
  wire logic       mon_cut    = monitor_enable && atten_tx_mode && lspk_above;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rx_switch_atten     <= RX_ATT_0DB;
      loudspeaker_amp     <= RST_CTRL;
      speakerphone_enable <= 1'b0;
      sidetone_sample     <= 16'h0000;
    end
    else
    begin
      rx_switch_atten     <= monitor_enable ? RX_ATT_0DB : rx_switch_atten_req;
      loudspeaker_amp     <= mon_cut ? mon_level : loudspeaker_level_ff;
      speakerphone_enable <= general_ctrl_ff[0];
      sidetone_sample     <= st_out;
    end
  end

  // ================================================================
  // Loop selects towards the analog side
  // ================================================================
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      loop_digital_shaper   <= 1'b0;
      loop_analog_front     <= 1'b0;
      loop_analog_converter <= 1'b0;
      loop_analog_shaper    <= 1'b0;
    end
    else
    begin
      loop_digital_shaper   <= loop_ctrl_ff[2];
      loop_analog_front     <= loop_ctrl_ff[3];
      loop_analog_converter <= loop_ctrl_ff[4];
      loop_analog_shaper    <= loop_ctrl_ff[5];
    end
  end

endmodule

// ---- logic/voice_dm_pkg.sv ----
package voice_dm_pkg;

  // ==================================================================
  // Register map (8-bit address space)
  // ==================================================================
  localparam logic [7:0] ADDR_GENERAL_CTRL = 8'h60;
  localparam logic [7:0] ADDR_PATH_CTRL    = 8'h61;
  localparam logic [7:0] ADDR_ATTEN_CTRL   = 8'h65;
  localparam logic [7:0] ADDR_LSPK_CTRL    = 8'h66;
  localparam logic [7:0] ADDR_FORMAT_SEL   = 8'h67;
  localparam logic [7:0] ADDR_SOURCE_SEL   = 8'h68;
  localparam logic [7:0] ADDR_CH1_MASK     = 8'h6a;
  localparam logic [7:0] ADDR_CH2_MASK     = 8'h6b;
  localparam logic [7:0] ADDR_LOOP_CTRL    = 8'h6d;
  localparam logic [7:0] ADDR_CRAM_BASE    = 8'h80;

  // Coefficient memory cells used by this block
  localparam logic [6:0] CRAM_IDX_ATT1     = 7'h0c;
  localparam logic [6:0] CRAM_IDX_ATT2     = 7'h0d;

  // ==================================================================
  // Reset values
  // ==================================================================
  localparam logic [7:0] RST_SOURCE_SEL    = 8'h3f;
  localparam logic [7:0] RST_FORMAT_SEL    = 8'h00;
  localparam logic [7:0] RST_MASK          = 8'h00;
  localparam logic [7:0] RST_CTRL          = 8'h00;

  // ==================================================================
  // Loudspeaker levels, attenuation in 0.5 dB steps
  // ==================================================================
  localparam logic [7:0] LSPK_ATT_9P5DB    = 8'h13;
  localparam logic [7:0] LSPK_ATT_21P5DB   = 8'h2b;
  localparam logic [7:0] RX_ATT_0DB        = 8'h00;

  // ==================================================================
  // Encodings
  // ==================================================================
  typedef enum logic [1:0] {
    TXSRC_CODEC = 2'h0,
    TXSRC_SUM   = 2'h1,
    TXSRC_BUS   = 2'h2,
    TXSRC_IDLE  = 2'h3
  } tx_src_t;

  typedef enum logic [1:0] {
    RXSRC_CH1  = 2'h0,
    RXSRC_CH2  = 2'h1,
    RXSRC_SUM  = 2'h2,
    RXSRC_IDLE = 2'h3
  } rx_src_t;

  typedef enum logic [1:0] {
    FMT_ALAW  = 2'h0,
    FMT_MULAW = 2'h1,
    FMT_LIN8  = 2'h2,
    FMT_LIN16 = 2'h3
  } fmt_t;

  typedef struct packed {
    logic    tx_ch2_enable;
    logic    tx_ch1_enable;
    rx_src_t rx_source_sel;
    tx_src_t tx_ch2_source_sel;
    tx_src_t tx_ch1_source_sel;
  } source_sel_t;

  typedef struct packed {
    logic ch2_linear8_rx;
    logic ch2_linear8_tx;
    logic ch1_linear8_rx;
    logic ch1_linear8_tx;
    fmt_t ch2_format_sel;
    fmt_t ch1_format_sel;
  } format_sel_t;

  typedef struct packed {
    logic [7:0] ch1_mask_value;
    logic [7:0] ch2_mask_value;
    format_sel_t fmt;
    source_sel_t src;
  } voice_cfg_t;

endpackage

// ---- tb/voice_bus_peer.sv ----
`timescale 1ns/1ps
module voice_bus_peer #(
  parameter int FRAME_LEN = 8
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  output logic             frame_sync,
  output logic      [15:0] bus_in_chan1,
  output logic      [15:0] bus_in_chan2
);
  int   seed = 32'h0c99;
  int   cnt  = 0;
  logic run;
  initial
  begin
    frame_sync   = 1'b0;
    bus_in_chan1 = 16'h0000;
    bus_in_chan2 = 16'h0000;
  end
  // ==========
  // Frame strobe and fresh channel words after each frame edge
  always @(posedge ref_clk)
  begin
    run = rst_n;
    #1;
    cnt        = run ? (cnt + 1) % FRAME_LEN : 0;
    frame_sync = run && cnt == FRAME_LEN - 1;
    if (cnt == 0)
    begin
      bus_in_chan1 = 16'($random(seed));
      bus_in_chan2 = 16'($random(seed));
    end
  end
endmodule

// ---- tb/voice_data_manip_props.sv ----
`timescale 1ns/1ps
module voice_dm_props
  import voice_dm_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        frame_sync,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic [15:0] codec_rx_sample,
  input wire logic [15:0] bus_out_chan1,
  input wire logic [15:0] bus_out_chan2,
  input wire logic        bus_out_chan1_oe_n,
  input wire logic        bus_out_chan2_oe_n,
  input wire logic        atten_tx_mode,
  input wire logic [7:0]  rx_switch_atten_req,
  input wire logic [7:0]  rx_switch_atten,
  input wire logic [7:0]  loudspeaker_amp,
  input wire logic [15:0] sidetone_post,
  input wire logic [15:0] sidetone_sample
);
  logic       mon_ff;
  logic [1:0] path_ff;
  // ==========
  // Shadow of monitoring and sidetone path settings
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      mon_ff  <= 1'b0;
      path_ff <= 2'h0;
    end
    else if (reg_wr && reg_addr == ADDR_GENERAL_CTRL)
      mon_ff <= &reg_wdata[1:0];
    else if (reg_wr && reg_addr == ADDR_PATH_CTRL)
      path_ff <= reg_wdata[1:0];
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_answer;
    reg_rvalid;
  endsequence
  sequence s_quiet;
    !reg_rvalid && reg_rdata == 8'h00;
  endsequence
  // ==========
  // Properties
  AST_RD_ANSWER: assert property (reg_rd |=> s_answer)
    else $error("read answer missing");
  AST_RD_QUIET: assert property (!reg_rd |=> s_quiet)
    else $error("read answer without request");
  AST_CH1_OFF: assert property (bus_out_chan1_oe_n |-> bus_out_chan1 == 16'h0000)
    else $error("channel one data while disabled");
  AST_CH2_OFF: assert property (bus_out_chan2_oe_n |-> bus_out_chan2 == 16'h0000)
    else $error("channel two data while disabled");
  AST_FRAME_HOLD: assert property (!frame_sync |=> $stable({bus_out_chan1, bus_out_chan2, codec_rx_sample}))
    else $error("voice output changed inside a frame");
  AST_OE_HOLD: assert property (!frame_sync |=> $stable({bus_out_chan1_oe_n, bus_out_chan2_oe_n}))
    else $error("drive enable changed inside a frame");
  AST_RX_SWITCH: assert property (##1 rx_switch_atten == ($past(mon_ff) ? RX_ATT_0DB : $past(rx_switch_atten_req)))
    else $error("receive switched attenuation wrong");
  AST_MON_LSPK: assert property (mon_ff && atten_tx_mode |=> loudspeaker_amp >= LSPK_ATT_9P5DB)
    else $error("loudspeaker not reduced in transmit mode");
  AST_TAP_POST: assert property (path_ff == 2'h3 |=> sidetone_sample == $past(sidetone_post))
    else $error("sidetone not taken after attenuation");
  AST_TAP_OFF: assert property (!path_ff[0] |=> sidetone_sample == 16'h0000)
    else $error("sidetone present while gain stage off");
endmodule
bind voice_data_manip voice_dm_props voice_dm_props_i (.ref_clk, .rst_n, .frame_sync, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .reg_rvalid, .codec_rx_sample, .bus_out_chan1, .bus_out_chan2, .bus_out_chan1_oe_n,
  .bus_out_chan2_oe_n, .atten_tx_mode, .rx_switch_atten_req, .rx_switch_atten, .loudspeaker_amp, .sidetone_post,
  .sidetone_sample);

// ---- tb/voice_data_manip_tb.sv ----
`timescale 1ns/1ps
module voice_data_manip_tb;
  import voice_dm_pkg::*;
  logic        ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, fix = 1'b0, chk_on = 1'b0;
  logic        frame_sync, reg_rvalid, bus_out_chan1_oe_n, bus_out_chan2_oe_n, atten_tx_mode, speakerphone_enable;
  logic        loop_digital_shaper, loop_analog_front, loop_analog_converter, loop_analog_shaper;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rx_switch_atten_req, rx_switch_atten, loudspeaker_amp, s, lv;
  logic [7:0]  cfg_src = 8'h3f, act_src = 8'h3f, cfg_fmt = 8'h00, act_fmt = 8'h00;
  logic [15:0] codec_tx_sample, codec_rx_sample, bus_in_chan1, bus_in_chan2, bus_out_chan1, bus_out_chan2;
  logic [15:0] sidetone_pre, sidetone_post, sidetone_sample, e1, e2, er, w0;
  logic [1:0]  eo = 2'h3;
  logic [15:0] idle [4] = '{16'h00d5, 16'h00ff, 16'h0000, 16'h0000};
  logic [7:0]  lvls [4] = '{8'h00, 8'h12, 8'h13, 8'h1e};
  int          seed = 32'h0c99, bad_count = 0, cmp_count = 0, x, a1, a2;
  voice_data_manip voice_data_manip_i (.ref_clk, .rst_n, .frame_sync, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .codec_tx_sample, .codec_rx_sample, .bus_in_chan1, .bus_in_chan2, .bus_out_chan1,
    .bus_out_chan2, .bus_out_chan1_oe_n, .bus_out_chan2_oe_n, .atten_tx_mode, .rx_switch_atten_req,
    .rx_switch_atten, .loudspeaker_amp, .speakerphone_enable, .sidetone_pre, .sidetone_post, .sidetone_sample,
    .loop_digital_shaper, .loop_analog_front, .loop_analog_converter, .loop_analog_shaper);
  voice_bus_peer #(.FRAME_LEN(8)) voice_bus_peer_i (.ref_clk, .rst_n, .frame_sync, .bus_in_chan1, .bus_in_chan2);
  always #2 ref_clk = ~ref_clk;
  // ==========
  // Reference model
  function automatic logic [15:0] sat(int v);
    return (v > 32767) ? 16'h7fff : (v < -32768) ? 16'h8000 : 16'(v);
  endfunction
  function automatic int pick(logic [1:0] sel, int p, int q);
    return (sel == 2'h0) ? p : (sel == 2'h1) ? p + q : (sel == 2'h2) ? q : 0;
  endfunction
  always @(posedge ref_clk)
    if (rst_n && frame_sync === 1'b1)
    begin
      x       = int'($signed(codec_tx_sample));
      a1      = int'($signed(bus_in_chan1)) >>> 1;
      a2      = int'($signed(bus_in_chan2)) >>> 2;
      e1      = act_src[6] ? sat(pick(act_src[1:0], x, a2)) : 16'h0000;
      e2      = act_src[7] ? sat(pick(act_src[3:2], x, a1)) : 16'h0000;
      er      = sat(pick({act_src[4], act_src[5]}, a1, a2));
      eo      = ~act_src[7:6];
      chk_on  = act_fmt == 8'h0f;
      act_src = cfg_src;
      act_fmt = cfg_fmt;
    end
  // ==========
  // Tasks
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    if (a == ADDR_SOURCE_SEL) cfg_src = d;
    if (a == ADDR_FORMAT_SEL) cfg_fmt = d;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge ref_clk);
    #1;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    chk("rdata", {8'h00, e}, {8'h00, reg_rdata});
  endtask
  task automatic frame();
    do @(posedge ref_clk); while (frame_sync !== 1'b1);
    #1;
    chk("oe_n", {14'h0, eo}, {14'h0, bus_out_chan2_oe_n, bus_out_chan1_oe_n});
    if (chk_on)
    begin
      chk("chan1", e1, bus_out_chan1);
      chk("chan2", e2, bus_out_chan2);
      chk("codec_rx", er, codec_rx_sample);
    end
    if (!fix) codec_tx_sample = 16'($random(seed));
    atten_tx_mode       = 1'($random(seed));
    rx_switch_atten_req = 8'($random(seed));
    sidetone_pre        = 16'($random(seed));
    sidetone_post       = 16'($random(seed));
  endtask
  task automatic conclude();
    $display("Counts: %0d compared, %0d mismatched", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========
  // Watchdog, about twenty-five times the expected run
  initial
  begin
    #60000;
    bad_count++;
    conclude();
  end
  // ==========
  // Tests
  initial
  begin
    {codec_tx_sample, rx_switch_atten_req, sidetone_pre, sidetone_post, reg_addr, reg_wdata, atten_tx_mode} = '0;
    repeat (6) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    chk("oe_n", 16'h0003, {14'h0, bus_out_chan2_oe_n, bus_out_chan1_oe_n});
    rd(ADDR_SOURCE_SEL, RST_SOURCE_SEL);
    rd(ADDR_FORMAT_SEL, RST_FORMAT_SEL);
    rd(ADDR_CH2_MASK, RST_MASK);
    rd(8'h70, 8'h00);
    wr(ADDR_CRAM_BASE | {1'b0, CRAM_IDX_ATT1}, 8'h01);
    wr(ADDR_CRAM_BASE | {1'b0, CRAM_IDX_ATT2}, 8'h02);
    rd(ADDR_CRAM_BASE | {1'b0, CRAM_IDX_ATT2}, 8'h02);
    wr(ADDR_CH1_MASK, 8'h5a);
    rd(ADDR_CH1_MASK, 8'h5a);
    wr(ADDR_FORMAT_SEL, 8'h0f);
    $display("Test registers done");
    for (int i = 0; i < 16; i++)
    begin
      s      = 8'($random(seed));
      s[3:0] = 4'(i);
      s[5:4] = 2'(i) + 2'(i >> 2);
      wr(ADDR_SOURCE_SEL, s);
      repeat (3) frame();
    end
    $display("Test traffic done");
    wr(ADDR_CH1_MASK, 8'h00);
    wr(ADDR_SOURCE_SEL, 8'h7f);
    for (int f = 0; f < 4; f++)
    begin
      wr(ADDR_FORMAT_SEL, 8'(f * 5));
      repeat (2) frame();
      chk("idle", idle[f], bus_out_chan1);
      chk("codec_rx", 16'h0000, codec_rx_sample);
    end
    $display("Test formats done");
    fix = 1'b1;
    wr(ADDR_FORMAT_SEL, 8'h02);
    wr(ADDR_SOURCE_SEL, 8'h7c);
    repeat (2) frame();
    w0 = bus_out_chan1;
    wr(ADDR_CH1_MASK, 8'ha5);
    repeat (2) frame();
    chk("mask", 16'h00a5, bus_out_chan1 ^ w0);
    wr(ADDR_FORMAT_SEL, 8'h12);
    repeat (2) frame();
    chk("lin8_code", 16'h0025, bus_out_chan1 ^ w0);
    fix = 1'b0;
    $display("Test mask done");
    wr(ADDR_GENERAL_CTRL, 8'h03);
    wr(ADDR_PATH_CTRL, 8'h03);
    chk("spk", 16'h0001, {15'h0, speakerphone_enable});
    for (int k = 0; k < 8; k++)
    begin
      lv = lvls[k % 4];
      wr(ADDR_ATTEN_CTRL, 8'(k / 4));
      wr(ADDR_LSPK_CTRL, lv);
      atten_tx_mode = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      chk("lspk", {8'h00, lv >= 8'h13 ? lv : (k > 3 ? LSPK_ATT_21P5DB : LSPK_ATT_9P5DB)}, {8'h00, loudspeaker_amp});
      chk("rx_att", 16'h0000, {8'h00, rx_switch_atten});
    end
    atten_tx_mode = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("lspk", {8'h00, lv}, {8'h00, loudspeaker_amp});
    $display("Test monitoring done");
    wr(ADDR_LOOP_CTRL, 8'h3c);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("loops", 16'h000f, {12'h0, loop_digital_shaper, loop_analog_front, loop_analog_converter, loop_analog_shaper});
    $display("Test loops done");
    conclude();
  end
endmodule
